// *** core/aorsm_host.sv ***
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module aorsm_host
    import aorsm_pkg::*;
#(
    parameter int QUIET_LEN = QUIET_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic gain_down,
    output logic gain_up,
    aorsm_link_if.host link
);

    typedef struct packed {
        logic [6:0] ctrl;
        logic [SAMPLE_W-1:0] thr_high;
        logic [SAMPLE_W-1:0] thr_low;
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] irq_en;
        logic mark_out;
        logic [SAMPLE_W-1:0] last_a;
        logic [SAMPLE_W-1:0] last_b;
        logic [QUIET_W-1:0] quiet;
        logic gain_down;
        logic gain_up;
        logic irq;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } aorsm_host_state_t;

    aorsm_host_state_t s_r;
    aorsm_host_state_t s_nxt;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == REG_CTRL || a == REG_THRESH || a == REG_STATUS || a == REG_CLEAR
            || a == REG_IRQ_EN || a == REG_LIVE || a == REG_SAMPLE;
    endfunction

    always_comb
    begin
        logic hi_or;
        logic lo_or;
        logic [NUM_EV-1:0] ev;
        logic [NUM_EV-1:0] clr;
        logic [DATA_W-1:0] rd;
        s_nxt = s_r;
        clr = '0;
        rd = '0;
        hi_or = link.chan_a_over_high_out | link.chan_b_over_high_out;
        lo_or = link.chan_a_over_low_out | link.chan_b_over_low_out;
        ev = '0;
        ev[EV_HIGH] = hi_or;
        ev[EV_LOW] = lo_or;
        ev[EV_MARK] = link.sample_valid && s_r.mark_out && (link.sample_a[0] | link.sample_b[0]);

        case (paddr)
            REG_CTRL: rd = {{(DATA_W-7){1'b0}}, s_r.ctrl};
            REG_THRESH: rd = {16'h0000, s_r.thr_low, s_r.thr_high};
            REG_STATUS: rd = {{(DATA_W-NUM_EV){1'b0}}, s_r.status};
            REG_IRQ_EN: rd = {{(DATA_W-NUM_EV){1'b0}}, s_r.irq_en};
            REG_LIVE: rd = {28'h0000000, link.chan_b_over_low_out, link.chan_b_over_high_out,
                            link.chan_a_over_low_out, link.chan_a_over_high_out};
            REG_SAMPLE: rd = {16'h0000, s_r.last_b, s_r.last_a};
            default: rd = '0;
        endcase

        // One wait state: data ready in the second access cycle
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && penable && !s_r.pready)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !mapped(paddr);
            s_nxt.prdata = pwrite ? '0 : rd;
        end
        if (psel && penable && s_r.pready && pwrite)
        begin
            case (paddr)
                REG_CTRL: s_nxt.ctrl = pwdata[6:0];
                REG_THRESH:
                begin
                    s_nxt.thr_high = pwdata[THR_HIGH_LSB +: SAMPLE_W];
                    s_nxt.thr_low = pwdata[THR_LOW_LSB +: SAMPLE_W];
                end
                REG_CLEAR: clr = pwdata[NUM_EV-1:0];
                REG_IRQ_EN: s_nxt.irq_en = pwdata[NUM_EV-1:0];
                default: clr = '0;
            endcase
        end

        // Set wins over a clear in the same cycle
        s_nxt.status = (s_r.status & ~clr) | ev;
        s_nxt.irq = |(s_nxt.status & s_nxt.irq_en);

        // Decimating mode suppresses marking
        s_nxt.mark_out = s_nxt.ctrl[CTRL_MARK_EN] && !s_nxt.ctrl[CTRL_DECIM];

        if (link.sample_valid)
        begin
            s_nxt.last_a = link.sample_a;
            s_nxt.last_b = link.sample_b;
        end

        // Gain hints: high trip lowers, long quiet on low raises
        s_nxt.gain_down = hi_or;
        if (lo_or)
        begin
            s_nxt.quiet = '0;
        end
        else if (s_r.quiet != QUIET_W'(QUIET_LEN))
        begin
            s_nxt.quiet = s_r.quiet + {{(QUIET_W-1){1'b0}}, 1'b1};
        end
        s_nxt.gain_up = s_nxt.quiet == QUIET_W'(QUIET_LEN);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.thr_high <= THR_HIGH_RST;
            s_r.thr_low <= THR_LOW_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;
    assign gain_down = s_r.gain_down;
    assign gain_up = s_r.gain_up;
    assign link.overrange_threshold_high = s_r.thr_high;
    assign link.overrange_threshold_low = s_r.thr_low;
    assign link.overrange_hold_select = s_r.ctrl[CTRL_HOLD_LSB +: HOLD_SEL_W];
    assign link.mark_enable = s_r.mark_out;
    assign link.single_mode = s_r.ctrl[CTRL_SINGLE];
    assign link.fg_cal = s_r.ctrl[CTRL_FG_CAL];

endmodule

// *** core/aorsm_pkg.sv ***
// Operation
// - Dual mode rising samples; single mode both edges
// - Samples are two's complement, sign from inputs
// - Two shared thresholds compare 8-bit magnitude
// - +127/-128 map ff, 0 to 00, -127 fe
// - Magnitude at or above threshold drives indication
// - Two outputs per channel, index0 high threshold
// - Single mode: OR channel outputs per threshold; the device keeps a and b apart, the host ORs them in every mode
// - Hold select 0..7 gives 8..1024 cycles
// - High trip lowers gain; long quiet raises
// - Marker only while enable set, else unchanged
// - Marked sample: upper 7 bits, marker LSB
// - Async marker input sampled with analog input; the code pairs each sample with the marker pin value from one edge earlier
// - No marking while decimating output mode selected
// - Foreground calibration stops sampling; background continues
// - One clock drives core, processing, outputs
package aorsm_pkg;
    localparam int SAMPLE_W = 8;
    localparam int HOLD_SEL_W = 3;
    localparam int HOLD_CNT_W = 11;
    localparam logic [HOLD_CNT_W-1:0] HOLD_BASE_CNT = 11'h008;
    localparam int NUM_OVR = 4;
    localparam int OVR_A_HIGH = 0;
    localparam int OVR_A_LOW = 1;
    localparam int OVR_B_HIGH = 2;
    localparam int OVR_B_LOW = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_THRESH = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CLEAR = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h10;
    localparam logic [ADDR_W-1:0] REG_LIVE = 8'h14;
    localparam logic [ADDR_W-1:0] REG_SAMPLE = 8'h18;
    localparam int CTRL_SINGLE = 0;
    localparam int CTRL_MARK_EN = 1;
    localparam int CTRL_DECIM = 2;
    localparam int CTRL_FG_CAL = 3;
    localparam int CTRL_HOLD_LSB = 4;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam int THR_HIGH_LSB = 0;
    localparam int THR_LOW_LSB = 8;
    localparam logic [SAMPLE_W-1:0] THR_HIGH_RST = 8'he4;
    localparam logic [SAMPLE_W-1:0] THR_LOW_RST = 8'h40;
    localparam int NUM_EV = 3;
    localparam int EV_HIGH = 0;
    localparam int EV_LOW = 1;
    localparam int EV_MARK = 2;
    localparam int QUIET_CYCLES = 1024;
    localparam int QUIET_W = 11;
endpackage

// *** core/aorsm_link_if.sv ***
`timescale 1ns/1ps
interface aorsm_link_if;
    import aorsm_pkg::*;
    logic [SAMPLE_W-1:0] overrange_threshold_high;
    logic [SAMPLE_W-1:0] overrange_threshold_low;
    logic [HOLD_SEL_W-1:0] overrange_hold_select;
    logic mark_enable;
    logic single_mode;
    logic fg_cal;
    logic chan_a_over_high_out;
    logic chan_a_over_low_out;
    logic chan_b_over_high_out;
    logic chan_b_over_low_out;
    logic [SAMPLE_W-1:0] sample_a;
    logic [SAMPLE_W-1:0] sample_b;
    logic sample_valid;
    modport device (
        input overrange_threshold_high, overrange_threshold_low, overrange_hold_select,
        input mark_enable, single_mode, fg_cal,
        output chan_a_over_high_out, chan_a_over_low_out, chan_b_over_high_out, chan_b_over_low_out,
        output sample_a, sample_b, sample_valid
    );
    modport host (
        output overrange_threshold_high, overrange_threshold_low, overrange_hold_select,
        output mark_enable, single_mode, fg_cal,
        input chan_a_over_high_out, chan_a_over_low_out, chan_b_over_high_out, chan_b_over_low_out,
        input sample_a, sample_b, sample_valid
    );
endinterface

// *** core/aorsm_device.sv ***
`timescale 1ns/1ps
module aorsm_device
    import aorsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    aorsm_link_if.device link,
    input wire logic [SAMPLE_W-1:0] analog_input_a_code,
    input wire logic [SAMPLE_W-1:0] analog_input_a_fall_code,
    input wire logic [SAMPLE_W-1:0] analog_input_b_code,
    input wire logic sample_mark_input,
    output logic converter_online
);

    typedef struct packed {
        logic [1:0] mark_sync;
        logic online;
        logic v_d1;
        logic [SAMPLE_W-1:0] a_d1;
        logic [SAMPLE_W-1:0] b_d1;
        logic [NUM_OVR-1:0][HOLD_CNT_W-1:0] hold_cnt;
        logic [NUM_OVR-1:0] over;
        logic out_v;
        logic [SAMPLE_W-1:0] out_a;
        logic [SAMPLE_W-1:0] out_b;
    } aorsm_dev_state_t;

    aorsm_dev_state_t s_r;
    aorsm_dev_state_t s_nxt;

    // Raw core code is offset binary; flip the sign bit
    function automatic logic [SAMPLE_W-1:0] to_twos(input logic [SAMPLE_W-1:0] raw);
        return {~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]};
    endfunction

    function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] neg;
        neg = (~s) + {{(SAMPLE_W-1){1'b0}}, 1'b1};
        if (!s[SAMPLE_W-1])
        begin
            return {s[SAMPLE_W-2:0], |s[SAMPLE_W-2:0]};
        end
        else if (neg[SAMPLE_W-1])
        begin
            return '1;
        end
        else
        begin
            return {neg[SAMPLE_W-2:0], 1'b0};
        end
    endfunction

    function automatic logic [HOLD_CNT_W-1:0] hold_len(input logic [HOLD_SEL_W-1:0] sel);
        return HOLD_BASE_CNT << sel;
    endfunction

    function automatic logic [SAMPLE_W-1:0] mark_sample(
        input logic [SAMPLE_W-1:0] s,
        input logic en,
        input logic mark
    );
        if (en)
        begin
            return {s[SAMPLE_W-1:1], mark};
        end
        else
        begin
            return s;
        end
    endfunction

    always_comb
    begin
        logic [SAMPLE_W-1:0] mag_a;
        logic [SAMPLE_W-1:0] mag_b;
        logic [NUM_OVR-1:0] trip;
        s_nxt = s_r;
        mag_a = magnitude(s_r.a_d1);
        mag_b = magnitude(s_r.b_d1);
        trip = '0;

        // Marker pin is asynchronous: two flops before use
        s_nxt.mark_sync = {s_r.mark_sync[0], sample_mark_input};

        // Foreground calibration takes the core offline
        s_nxt.online = !link.fg_cal;
        s_nxt.v_d1 = !link.fg_cal;

        // Capture: channel b carries the falling-edge sample in single mode
        s_nxt.a_d1 = to_twos(analog_input_a_code);
        if (link.single_mode)
        begin
            s_nxt.b_d1 = to_twos(analog_input_a_fall_code);
        end
        else
        begin
            s_nxt.b_d1 = to_twos(analog_input_b_code);
        end

        // Both samples of the cycle against both thresholds
        if (s_r.v_d1)
        begin
            trip[OVR_A_HIGH] = mag_a >= link.overrange_threshold_high;
            trip[OVR_A_LOW] = mag_a >= link.overrange_threshold_low;
            trip[OVR_B_HIGH] = mag_b >= link.overrange_threshold_high;
            trip[OVR_B_LOW] = mag_b >= link.overrange_threshold_low;
        end

        for (int k = 0; k < NUM_OVR; k++)
        begin
            if (trip[k])
            begin
                s_nxt.hold_cnt[k] = hold_len(link.overrange_hold_select);
            end
            else if (s_r.hold_cnt[k] != '0)
            begin
                s_nxt.hold_cnt[k] = s_r.hold_cnt[k] - {{(HOLD_CNT_W-1){1'b0}}, 1'b1};
            end
            s_nxt.over[k] = s_nxt.hold_cnt[k] != '0;
        end

        // Output stage: marker flop two edges after pin, one edge more than the data
        s_nxt.out_v = s_r.v_d1;
        if (s_r.v_d1)
        begin
            s_nxt.out_a = mark_sample(s_r.a_d1, link.mark_enable, s_r.mark_sync[1]);
            s_nxt.out_b = mark_sample(s_r.b_d1, link.mark_enable, s_r.mark_sync[1]);
        end
        else
        begin
            s_nxt.out_a = '0;
            s_nxt.out_b = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign link.chan_a_over_high_out = s_r.over[OVR_A_HIGH];
    assign link.chan_a_over_low_out = s_r.over[OVR_A_LOW];
    assign link.chan_b_over_high_out = s_r.over[OVR_B_HIGH];
    assign link.chan_b_over_low_out = s_r.over[OVR_B_LOW];
    assign link.sample_a = s_r.out_a;
    assign link.sample_b = s_r.out_b;
    assign link.sample_valid = s_r.out_v;
    assign converter_online = s_r.online;

endmodule

// *** test/aorsm_checker.sv ***
`timescale 1ns/1ps
module aorsm_checker
    import aorsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [SAMPLE_W-1:0] overrange_threshold_high,
    input wire logic [SAMPLE_W-1:0] overrange_threshold_low,
    input wire logic [HOLD_SEL_W-1:0] overrange_hold_select,
    input wire logic mark_enable,
    input wire logic fg_cal,
    input wire logic chan_a_over_high_out,
    input wire logic chan_a_over_low_out,
    input wire logic chan_b_over_high_out,
    input wire logic chan_b_over_low_out,
    input wire logic [SAMPLE_W-1:0] sample_a,
    input wire logic [SAMPLE_W-1:0] sample_b,
    input wire logic sample_valid
);
    logic [10:0] run_r;
    function automatic logic [7:0] mag(input logic [7:0] s);
        return s[7] ? ((s == 8'h80) ? 8'hff : (~s + 8'h01) << 1) : {s[6:0], |s[6:0]};
    endfunction
    // Length of the current high run
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            run_r <= '0;
        else
            run_r <= chan_a_over_high_out ? run_r + 11'h001 : '0;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_cal;
        fg_cal [*3];
    endsequence
    sequence s_ok;
        sample_valid && !$past(mark_enable);
    endsequence
    chk_reset_low: assert property ($past(rst) |-> !(chan_a_over_high_out || chan_a_over_low_out
        || chan_b_over_high_out || chan_b_over_low_out)) else $error("overrange after reset");
    chk_cal_quiet: assert property (s_cal |-> !sample_valid && sample_a == 8'h00)
        else $error("sample during cal");
    chk_a_high_trip: assert property (s_ok ##0 mag(sample_a) >= $past(overrange_threshold_high)
        |-> chan_a_over_high_out) else $error("a high missed");
    chk_a_low_trip: assert property (s_ok ##0 mag(sample_a) >= $past(overrange_threshold_low)
        |-> chan_a_over_low_out) else $error("a low missed");
    chk_b_high_trip: assert property (s_ok ##0 mag(sample_b) >= $past(overrange_threshold_high)
        |-> chan_b_over_high_out) else $error("b high missed");
    chk_b_low_trip: assert property (s_ok ##0 mag(sample_b) >= $past(overrange_threshold_low)
        |-> chan_b_over_low_out) else $error("b low missed");
    chk_rise_cause: assert property ($rose(chan_a_over_high_out) && !$past(mark_enable)
        |-> sample_valid && mag(sample_a) >= $past(overrange_threshold_high)) else $error("false trip");
    chk_hold_min: assert property ($fell(chan_a_over_high_out)
        |-> run_r >= (11'h008 << $past(overrange_hold_select))) else $error("hold short");
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb;
    import aorsm_pkg::*;
    logic ref_clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic mark = 0;
    logic er;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata, rd;
    logic pready, pslverr, irq, gdn, gup, online;
    logic [SAMPLE_W-1:0] ca = 8'h80, cf = 8'h80, cb = 8'h80;
    int bad_count = 0, checked = 0, cyc = 0, n;
    aorsm_link_if link();
    aorsm_device u_aorsm_device(.ref_clk(ref_clk), .rst(rst), .link(link), .analog_input_a_code(ca),
        .analog_input_a_fall_code(cf), .analog_input_b_code(cb), .sample_mark_input(mark), .converter_online(online));
    aorsm_host #(.QUIET_LEN(16)) u_aorsm_host(.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .gain_down(gdn), .gain_up(gup), .link(link));
    aorsm_checker u_aorsm_checker(.ref_clk(ref_clk), .rst(rst), .mark_enable(link.mark_enable),
        .overrange_threshold_high(link.overrange_threshold_high), .fg_cal(link.fg_cal),
        .overrange_threshold_low(link.overrange_threshold_low), .overrange_hold_select(link.overrange_hold_select),
        .chan_a_over_high_out(link.chan_a_over_high_out), .chan_a_over_low_out(link.chan_a_over_low_out),
        .chan_b_over_high_out(link.chan_b_over_high_out), .chan_b_over_low_out(link.chan_b_over_low_out),
        .sample_a(link.sample_a), .sample_b(link.sample_b), .sample_valid(link.sample_valid));
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            $display("Error %0t: timeout", $time);
            bad_count++;
            close_out;
        end
    end
    task close_out;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        // Wait for the answer; only the bench timeout ends a hang
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask
    task step(input logic [7:0] a, input logic [7:0] f, input logic [7:0] b);
        ca <= a;
        cf <= f;
        cb <= b;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task rest;
        @(posedge ref_clk);
        ca <= 8'h80;
        cf <= 8'h80;
        cb <= 8'h80;
        repeat (14) @(posedge ref_clk);
    endtask
    task pulse;
        @(posedge ref_clk);
        ca <= 8'hff;
        @(posedge ref_clk);
        ca <= 8'h80;
    endtask
    task cnt;
        n = 0;
        @(negedge ref_clk);
        while (link.chan_a_over_high_out === 1'b1 && n < 1100)
        begin
            n++;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask
    task t_mag;
        logic [7:0] c[4] = '{8'hff, 8'h80, 8'h01, 8'h00};
        logic [7:0] m[4] = '{8'hff, 8'h00, 8'hfe, 8'hff};
        apb(1, REG_THRESH, 32'h0000feff);
        foreach (c[i])
        begin
            step(c[i], 8'h80, c[i]);
            `CHK(link.sample_a, {~c[i][7], c[i][6:0]})
            `CHK(link.chan_a_over_high_out, m[i] >= 8'hff)
            `CHK(link.chan_a_over_low_out, m[i] >= 8'hfe)
            `CHK(link.chan_b_over_high_out, m[i] >= 8'hff)
            `CHK(link.chan_b_over_low_out, m[i] >= 8'hfe)
            rest;
        end
        $display("magnitude test done");
    endtask
    task t_hold;
        apb(1, REG_THRESH, 32'h000040e4);
        for (int s = 0; s < 8; s++)
        begin
            apb(1, REG_CTRL, s << 4);
            pulse;
            @(posedge ref_clk);
            cnt;
            `CHK(n, 8 << s)
        end
        apb(1, REG_CTRL, 0);
        pulse;
        pulse;
        cnt;
        // Second trip two cycles on: counted from its capture cycle
        `CHK(n, 9)
        $display("hold test done");
    endtask
    task t_single;
        step(8'h80, 8'hff, 8'h80);
        `CHK(link.chan_b_over_high_out, 1'b0)
        rest;
        apb(1, REG_CTRL, 1);
        step(8'h80, 8'hff, 8'h80);
        `CHK({link.sample_b, link.chan_b_over_high_out, link.chan_a_over_high_out}, 10'h1fe)
        @(negedge ref_clk);
        `CHK(gdn, 1'b1)
        `CHK(gup, 1'b0)
        rest;
        apb(1, REG_CTRL, 0);
        $display("single test done");
    endtask
    task t_mark;
        logic mm[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic [31:0] mc[4] = '{2, 2, 6, 0};
        logic [7:0] me[4] = '{8'h01, 8'h00, 8'h00, 8'h00};
        foreach (mm[i])
        begin
            mark <= mm[i];
            apb(1, REG_CTRL, mc[i]);
            step(8'h80, 8'h80, 8'h80);
            `CHK({link.sample_a, link.sample_b}, {me[i], me[i]})
            @(posedge ref_clk);
            apb(0, REG_SAMPLE, 0);
            `CHK(rd[15:0], {me[i], me[i]})
        end
        $display("marker test done");
    endtask
    task t_cal;
        // Low outputs quiet for well over QUIET_LEN cycles by now
        `CHK(gup, 1'b1)
        apb(1, REG_CTRL, 8);
        repeat (3) @(negedge ref_clk);
        `CHK({online, link.sample_valid}, 2'b00)
        @(posedge ref_clk);
        apb(1, REG_CTRL, 0);
        repeat (3) @(negedge ref_clk);
        `CHK({online, link.sample_valid}, 2'b11)
        @(posedge ref_clk);
        $display("cal test done");
    endtask
    task t_irq;
        apb(1, REG_IRQ_EN, 1);
        apb(1, REG_CLEAR, 7);
        `CHK(irq, 1'b0)
        pulse;
        repeat (4) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        apb(0, REG_LIVE, 0);
        `CHK(rd[3:0], 4'h3)
        apb(0, REG_STATUS, 0);
        `CHK(rd[0], 1'b1)
        cnt;
        apb(1, REG_CLEAR, 1);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        @(posedge ref_clk);
        apb(0, 8'h40, 0);
        `CHK({er, rd}, 33'h100000000)
        $display("irq test done");
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        @(negedge ref_clk);
        `CHK({link.chan_a_over_high_out, link.chan_b_over_low_out}, 2'b00)
        @(posedge ref_clk);
        apb(0, REG_THRESH, 0);
        `CHK(rd[15:0], 16'h40e4)
        t_mag;
        t_hold;
        t_single;
        t_mark;
        t_cal;
        t_irq;
        close_out;
    end
endmodule
